// ===== hw/run_seq_consts.vh
// Constants for the motor run and speed sequencer
// Function
// - Forward run alone drives the motor forward at the selected speed.
// - Reverse run alone drives the motor in reverse at the selected speed.
// - Releasing the run input while turning ramps down using deceleration time.
// - Both run inputs active stop the motor instantly, no ramp.
// - Run input active at power-up raises alarm 46 and blocks running.
// - Test operation runs the motor at a fixed 300 r/min.
// - Run input active when test would start gives an error instead.
// - Test cannot start while coast-release is active.
// - Setpoint limited to 90-1400 r/min at 50 Hz, 90-1600 at 60 Hz; the stored setpoint is clamped to 90-1600 at both.
// - At 50 Hz a setpoint above 1400 runs at about 1420 r/min.
// - Panel speed settings are accepted while running and at standstill.
// - Remote speed used only when enabled and both data selects inactive.
// - Remote full scale selectable as 0-5 V (default) or 0-10 V.
// - Acceleration and deceleration times adjustable 0 to 15.0 s.
// - Panel speed ramps take the set time from present to new target.
// - Remote speed ramps take the set time per 1000 r/min change.
// - Direction parameter picks which shaft sense the forward input gives.
// - Polarity switch selects sink or source inputs, sink by default.
// - Coast-release removes drive and makes run inputs ignored.
// - Data-select inputs choose which stored data set is used.
`ifndef RUN_SEQ_CONSTS_VH
`define RUN_SEQ_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TEST 8'h08
`define REG_SPEED0 8'h10
`define REG_ACCEL0 8'h20
`define REG_DECEL0 8'h30

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define CTRL_EXT_EN 0
`define CTRL_RANGE_10V 1
`define CTRL_DIR_CCW 2
`define CTRL_HZ60 3
`define CTRL_RESET 4'h0
`define TEST_START 0
`define TEST_STOP 1
`define TEST_CLR_ERR 2

// ----------------------------------------
// Speed and time figures
// ----------------------------------------
`define SPD_MIN 11'h05A
`define SPD_MAX_50 11'h578
`define SPD_MAX_60 11'h640
`define SPD_OVER_50 11'h58C
`define SPD_TEST 11'h12C
`define SPD_REMOTE_REF 11'h3E8
`define SPD_RESET 11'h3E8
`define TIME_MAX 8'h96
`define TIME_RESET 8'h05
`define ALARM_CODE 8'h2E

// Clock period and timing counts
`define CLK_NS 20
`define RAMP_TICK_NS 10000
`define RAMP_TICK_CYC (`RAMP_TICK_NS / `CLK_NS)
`define TICKS_PER_TENTH 22'h002710
`define FILT_MS 1
`define FILT_CYC (`FILT_MS * 1000000 / `CLK_NS)

`endif

// ===== hw/input_filter.v
// Two-flop synchroniser with a stability filter for one control input
`default_nettype none

module input_filter #(
  parameter CNT_W = 16,
  parameter CNT = 50000
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire ce_i,
  // Raw and filtered level
  input wire raw_i,
  output reg clean_o
);

  reg sync1;
  reg sync2;
  reg [CNT_W-1:0] cnt;

  // Synchronise, then accept a new level only after it stays for CNT cycles
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      cnt <= {CNT_W{1'b0}};
      clean_o <= 1'b0;
    end else if (ce_i) begin
      sync1 <= raw_i;
      sync2 <= sync1;
      if (sync2 == clean_o) begin
        cnt <= {CNT_W{1'b0}};
      end else if (cnt == CNT[CNT_W-1:0] - 1'b1) begin
        cnt <= {CNT_W{1'b0}};
        clean_o <= sync2;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ===== hw/motor_run_speed_sequencer.v
// Run decoding, alarm, test mode and speed ramp of the motor controller
`include "run_seq_consts.vh"
`default_nettype none

module motor_run_speed_sequencer #(
  parameter FILT_CYCLES = `FILT_CYC,
  parameter FILT_W = 17
) (
  // Clock, reset, enable
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire ce_i,
  // Isolated control inputs
  input wire forward_run_input_i,
  input wire reverse_run_input_i,
  input wire data_select_bit0_i,
  input wire data_select_bit1_i,
  input wire coast_release_i,
  input wire alarm_reset_i,
  input wire input_polarity_switch_i,
  // Remote speed command, 0 to 10 V over full code range
  input wire [9:0] remote_cmd_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  // Motor drive
  output reg drive_en_o,
  output reg dir_cw_o,
  output reg [10:0] speed_o,
  // Status
  output reg power_on_run_alarm_o,
  output reg [7:0] alarm_code_o,
  output reg test_active_o,
  output reg test_error_o
);

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  wire [5:0] raw_in;
  wire [5:0] clean;

  // Source polarity inverts every input level
  assign raw_in = {alarm_reset_i, coast_release_i, data_select_bit1_i,
                   data_select_bit0_i, reverse_run_input_i, forward_run_input_i}
                  ^ {6{input_polarity_switch_i}};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_filt
      input_filter #(
        .CNT_W(FILT_W),
        .CNT(FILT_CYCLES)
      ) u_filt (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .raw_i(raw_in[gi]),
        .clean_o(clean[gi])
      );
    end
  endgenerate

  wire forward_run_input = clean[0];
  wire reverse_run_input = clean[1];
  wire [1:0] sel = clean[3:2];
  wire coast = clean[4];
  wire alm_rst = clean[5];
  wire any_run = forward_run_input | reverse_run_input;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [3:0] ctrl;
  reg [10:0] spd_set [0:3];
  reg [7:0] acc_set [0:3];
  reg [7:0] dec_set [0:3];
  integer i;

  wire ext_en = ctrl[`CTRL_EXT_EN];
  wire rng10 = ctrl[`CTRL_RANGE_10V];
  wire dir_ccw = ctrl[`CTRL_DIR_CCW];
  wire hz60 = ctrl[`CTRL_HZ60];
  wire [1:0] widx = addr_i[3:2];
  wire wr_test = wr_i & (addr_i == `REG_TEST);

  // Clamp a written speed to the widest setting range
  function [10:0] clamp_spd;
    input [15:0] v;
    begin
      if (v < {5'h00, `SPD_MIN}) begin
        clamp_spd = `SPD_MIN;
      end else if (v > {5'h00, `SPD_MAX_60}) begin
        clamp_spd = `SPD_MAX_60;
      end else begin
        clamp_spd = v[10:0];
      end
    end
  endfunction

  // Clamp a ramp time in tenths of a second
  function [7:0] clamp_time;
    input [15:0] v;
    begin
      if (v > {8'h00, `TIME_MAX}) begin
        clamp_time = `TIME_MAX;
      end else begin
        clamp_time = v[7:0];
      end
    end
  endfunction

  // Register writes, accepted in any motor state
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= `CTRL_RESET;
      for (i = 0; i < 4; i = i + 1) begin
        spd_set[i] <= `SPD_RESET;
        acc_set[i] <= `TIME_RESET;
        dec_set[i] <= `TIME_RESET;
      end
    end else if (ce_i && wr_i) begin
      if (addr_i == `REG_CTRL) begin
        ctrl <= wdata_i[3:0];
      end
      if ({addr_i[7:4], 4'h0} == `REG_SPEED0) begin
        spd_set[widx] <= clamp_spd(wdata_i);
      end
      if ({addr_i[7:4], 4'h0} == `REG_ACCEL0) begin
        acc_set[widx] <= clamp_time(wdata_i);
      end
      if ({addr_i[7:4], 4'h0} == `REG_DECEL0) begin
        dec_set[widx] <= clamp_time(wdata_i);
      end
    end
  end

  // ----------------------------------------
  // Speed source selection
  // ----------------------------------------
  wire remote = ext_en & (sel == 2'b00);
  wire [9:0] scaled;
  wire [14:0] rem_prod;
  wire [10:0] rem_spd;
  wire [10:0] raw_spd;
  wire [10:0] lim_spd;
  wire [10:0] sel_spd;

  // 0-5 V range doubles the code and saturates above half scale
  assign scaled = rng10 ? remote_cmd_i :
                  (remote_cmd_i[9] ? 10'h3FF : {remote_cmd_i[8:0], 1'b0});
  assign rem_prod = {5'h00, scaled} * 15'h0019;
  assign rem_spd = rem_prod[14:4];
  assign raw_spd = remote ? clamp_spd({5'h00, rem_spd}) : spd_set[sel];

  // 50 Hz supply cannot exceed its limit but settles near 1420 r/min
  assign lim_spd = (!hz60 && raw_spd > `SPD_MAX_50) ? `SPD_OVER_50 : raw_spd;
  assign sel_spd = lim_spd;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  localparam [2:0] ST_INIT = 3'h0;
  localparam [2:0] ST_RUN = 3'h1;
  localparam [2:0] ST_ALARM = 3'h2;
  localparam [2:0] ST_TEST = 3'h3;

  reg [2:0] state;
  reg [FILT_W+1:0] init_cnt;
  reg [10:0] spd;
  reg dir_fwd;

  wire init_done = (init_cnt == FILT_CYCLES[FILT_W-1:0] + {{(FILT_W-3){1'b0}}, 3'h4});
  wire both = forward_run_input & reverse_run_input;
  wire want_fwd = forward_run_input & ~reverse_run_input;
  wire want_rev = reverse_run_input & ~forward_run_input;

  // Mode control: power-up check, alarm latch, test entry and exit
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_INIT;
      init_cnt <= {(FILT_W+2){1'b0}};
      test_error_o <= 1'b0;
    end else if (ce_i) begin
      case (state)
        ST_INIT: begin
          // Wait until filtered inputs have settled
          if (init_done) begin
            state <= any_run ? ST_ALARM : ST_RUN;
          end else begin
            init_cnt <= init_cnt + 1'b1;
          end
        end
        ST_ALARM: begin
          if (alm_rst && !any_run) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (wr_test && wdata_i[`TEST_START] && !coast) begin
            if (any_run) begin
              test_error_o <= 1'b1;
            end else if (spd == 11'h000) begin
              state <= ST_TEST;
            end
          end
        end
        ST_TEST: begin
          if (coast || (wr_test && wdata_i[`TEST_STOP])) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_INIT;
        end
      endcase
      // Error set wins over a simultaneous clear
      if (wr_test && wdata_i[`TEST_CLR_ERR] &&
          !(state == ST_RUN && wdata_i[`TEST_START] && !coast && any_run)) begin
        test_error_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Target speed and stop decoding
  // ----------------------------------------
  reg [10:0] tgt;
  reg instant;
  reg run_dir_fwd;

  always @* begin
    tgt = 11'h000;
    instant = 1'b0;
    run_dir_fwd = dir_fwd;
    if (state == ST_TEST) begin
      instant = 1'b1;
      tgt = coast ? 11'h000 : `SPD_TEST;
      run_dir_fwd = 1'b1;
    end else if (state != ST_RUN || coast) begin
      instant = 1'b1;
    end else if (both) begin
      instant = 1'b1;
    end else if (want_fwd || want_rev) begin
      run_dir_fwd = want_fwd;
      // A reversal decelerates to standstill before turning the other way
      if (spd == 11'h000 || dir_fwd == want_fwd) begin
        tgt = sel_spd;
      end
    end
    // Otherwise the target is zero and the motor ramps down
  end

  // ----------------------------------------
  // Ramp generator
  // ----------------------------------------
  reg [8:0] tick_cnt;
  reg [10:0] tgt_q;
  reg [10:0] delta;
  reg [21:0] acc;
  wire tick = (tick_cnt == `RAMP_TICK_CYC - 1);
  wire going_up = tgt > spd;
  wire [7:0] tsel = going_up ? acc_set[sel] : dec_set[sel];
  wire [21:0] period = {14'h0000, tsel} * `TICKS_PER_TENTH;
  wire [10:0] gap = going_up ? tgt - spd : spd - tgt;
  wire [21:0] acc_next = acc + {11'h000, delta};

  // Bresenham stepping: delta steps spread over the set period
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt <= 9'h000;
      tgt_q <= 11'h000;
      delta <= 11'h000;
      acc <= 22'h000000;
      spd <= 11'h000;
      dir_fwd <= 1'b1;
    end else if (ce_i) begin
      tick_cnt <= tick ? 9'h000 : tick_cnt + 1'b1;
      tgt_q <= tgt;
      if (spd == 11'h000) begin
        dir_fwd <= run_dir_fwd;
      end
      if (instant) begin
        spd <= tgt;
        acc <= 22'h000000;
      end else if (tgt != tgt_q) begin
        // New target: remote ramps use a fixed 1000 r/min reference
        delta <= remote ? `SPD_REMOTE_REF : gap;
        acc <= 22'h000000;
      end else if (tgt != spd) begin
        if (tsel == 8'h00) begin
          spd <= tgt; // Zero ramp time jumps straight to target
        end else if (tick) begin
          if (acc_next >= period) begin
            acc <= acc_next - period;
            spd <= going_up ? spd + 1'b1 : spd - 1'b1;
          end else begin
            acc <= acc_next;
          end
        end
      end else begin
        acc <= 22'h000000;
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Registered drive and status outputs
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drive_en_o <= 1'b0;
      dir_cw_o <= 1'b1;
      speed_o <= 11'h000;
      power_on_run_alarm_o <= 1'b0;
      alarm_code_o <= 8'h00;
      test_active_o <= 1'b0;
    end else if (ce_i) begin
      drive_en_o <= !coast && (spd != 11'h000 || tgt != 11'h000);
      dir_cw_o <= dir_fwd ^ dir_ccw;
      speed_o <= spd;
      power_on_run_alarm_o <= (state == ST_ALARM);
      alarm_code_o <= (state == ST_ALARM) ? `ALARM_CODE : 8'h00;
      test_active_o <= (state == ST_TEST);
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  reg [15:0] next_rdata;

  // Read data appear one cycle after the read strobe; others read zero
  always @* begin
    next_rdata = 16'h0000;
    if (addr_i == `REG_CTRL) begin
      next_rdata = {12'h000, ctrl};
    end else if (addr_i == `REG_STATUS) begin
      next_rdata = {spd, state == ST_TEST, test_error_o,
                    state == ST_ALARM, dir_fwd, drive_en_o};
    end else if ({addr_i[7:4], 4'h0} == `REG_SPEED0) begin
      next_rdata = {5'h00, spd_set[widx]};
    end else if ({addr_i[7:4], 4'h0} == `REG_ACCEL0) begin
      next_rdata = {8'h00, acc_set[widx]};
    end else if ({addr_i[7:4], 4'h0} == `REG_DECEL0) begin
      next_rdata = {8'h00, dec_set[widx]};
    end
  end

  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      rdata_o <= rd_i ? next_rdata : 16'h0000;
    end
  end

endmodule

`default_nettype wire

// ===== testbench/motor_run_speed_sequencer_properties.sv
// Port checks for the motor run and speed sequencer
`default_nettype none
module motor_run_speed_sequencer_properties #(
  parameter FILT_CYCLES = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  // Inputs
  input wire logic forward_run_input_i,
  input wire logic reverse_run_input_i,
  input wire logic coast_release_i,
  input wire logic input_polarity_switch_i,
  input wire logic rd_i,
  // Outputs
  input wire logic [15:0] rdata_o,
  input wire logic drive_en_o,
  input wire logic dir_cw_o,
  input wire logic [10:0] speed_o,
  input wire logic power_on_run_alarm_o,
  input wire logic [7:0] alarm_code_o,
  input wire logic test_active_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int THR = FILT_CYCLES + 6;
  logic coast_act;
  logic both_act;
  logic [15:0] coast_cnt;
  logic [15:0] both_cnt;
  // Active levels after the polarity switch
  assign coast_act = coast_release_i ^ input_polarity_switch_i;
  assign both_act = (forward_run_input_i ^ input_polarity_switch_i) & (reverse_run_input_i ^ input_polarity_switch_i);
  // Saturating counts of how long coast and both runs stay active; a frozen block restarts them
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      coast_cnt <= 16'h0000;
      both_cnt <= 16'h0000;
    end else begin
      coast_cnt <= (!coast_act || !ce_i) ? 16'h0000 : (coast_cnt == 16'hFFFF) ? coast_cnt : coast_cnt + 16'h0001;
      both_cnt <= (!both_act || !ce_i) ? 16'h0000 : (both_cnt == 16'hFFFF) ? both_cnt : both_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  chk_alarm_code_tracks: assert property (alarm_code_o == (power_on_run_alarm_o ? 8'h2E : 8'h00))
    else $error("alarm code wrong");
  chk_alarm_blocks_drive: assert property (power_on_run_alarm_o && $past(power_on_run_alarm_o) |-> !drive_en_o)
    else $error("drive during alarm");
  chk_speed_ceiling: assert property (speed_o <= 11'h640)
    else $error("speed above ceiling");
  chk_test_fixed_speed: assert property (test_active_o && $past(test_active_o) |-> drive_en_o && speed_o == 11'h12C)
    else $error("test speed wrong");
  chk_coast_no_drive: assert property (coast_cnt >= THR |-> !drive_en_o && speed_o == 11'h000)
    else $error("drive while coasting");
  chk_coast_no_test: assert property (coast_cnt >= THR |-> !$rose(test_active_o))
    else $error("test started while coasting");
  chk_both_stop: assert property (both_cnt >= THR && !test_active_o |-> speed_o == 11'h000)
    else $error("speed with both runs on");
  chk_dir_hold_turning: assert property (drive_en_o && speed_o != 11'h000 && $past(speed_o) != 11'h000 |-> $stable(dir_cw_o))
    else $error("direction flipped while turning");
  chk_read_quiet: assert property (rdata_o != 16'h0000 |-> $past(rd_i))
    else $error("read data outside read slot");
endmodule
`default_nettype wire

// ===== testbench/run_controller_model.sv
// Controller model driving the isolated control inputs
`default_nettype none
module run_controller_model #(
  parameter int HOLD = 12
) (
  // Clock and polarity
  input wire logic ref_clk_i,
  input wire logic pol_i,
  // Requested levels {alarm reset, coast, sel1, sel0, rev, fwd}
  input wire logic [5:0] req_i,
  // Terminal levels
  output logic [5:0] raw_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cur = 6'h00;
  int hold_cnt = 0;
  // A level stands at least HOLD cycles before it may change
  always @(posedge ref_clk_i) begin
    if (hold_cnt != 0) begin
      hold_cnt <= hold_cnt - 1;
    end else if (req_i != cur) begin
      cur <= req_i;
      hold_cnt <= HOLD;
    end
  end
  // Source wiring inverts every level
  assign raw_o = cur ^ {6{pol_i}};
endmodule
`default_nettype wire

// ===== testbench/test_motor_run_speed_sequencer.sv
// Self-checking bench for the motor run and speed sequencer
`default_nettype none
module test_motor_run_speed_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic pol = 1'b0;
  logic ce = 1'b1;
  logic [5:0] req = 6'h01;
  logic [9:0] remote = 10'h000;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  wire [5:0] raw;
  wire [15:0] rdata;
  wire [10:0] speed;
  wire [7:0] code;
  wire drive_en, dir_cw, alarm, test_act, test_err;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  motor_run_speed_sequencer #(.FILT_CYCLES(8), .FILT_W(17)) dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .ce_i(ce), .forward_run_input_i(raw[0]), .reverse_run_input_i(raw[1]), .data_select_bit0_i(raw[2]),
    .data_select_bit1_i(raw[3]), .coast_release_i(raw[4]), .alarm_reset_i(raw[5]), .input_polarity_switch_i(pol),
    .remote_cmd_i(remote), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .drive_en_o(drive_en), .dir_cw_o(dir_cw), .speed_o(speed), .power_on_run_alarm_o(alarm),
    .alarm_code_o(code), .test_active_o(test_act), .test_error_o(test_err));
  run_controller_model model_u (.ref_clk_i(ref_clk_i), .pol_i(pol), .req_i(req), .raw_o(raw));
  // Clock and hang guard
  initial forever #10 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end
  function automatic logic [15:0] motor();
    return {3'b000, drive_en, dir_cw, speed};
  endfunction
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic go(input logic [5:0] r);
    req <= r;
    repeat (40) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    chk("register", rdata, exp);
  endtask
  task automatic test_cmd(input logic [15:0] d);
    wr_reg(8'h08, d);
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    go(6'h01);
    chk("alarm", {15'h0000, alarm}, 16'h0001);
    chk("code", {8'h00, code}, 16'h002E);
    chk("motor", motor(), 16'h0800);
    go(6'h00);
    go(6'h20);
    go(6'h00);
    chk("alarm", {15'h0000, alarm}, 16'h0000);
    rd_chk(8'h00, 16'h0000);
    rd_chk(8'h10, 16'h03E8);
    rd_chk(8'h20, 16'h0005);
    rd_chk(8'h30, 16'h0005);
    rd_chk(8'hFC, 16'h0000);
    wr_reg(8'h2C, 16'h00C8);
    rd_chk(8'h2C, 16'h0096);
    wr_reg(8'h1C, 16'h07D0);
    rd_chk(8'h1C, 16'h0640);
    wr_reg(8'h18, 16'h0032);
    rd_chk(8'h18, 16'h005A);
    wr_reg(8'h20, 16'h0000);
    wr_reg(8'h30, 16'h0000);
    wr_reg(8'h24, 16'h0000);
    wr_reg(8'h34, 16'h0000);
    wr_reg(8'h10, 16'h0258);
    wr_reg(8'h14, 16'h0320);
    go(6'h01);
    chk("motor", motor(), 16'h1A58);
    rd_chk(8'h04, 16'h4B03);
    wr_reg(8'h10, 16'h02BC);
    go(6'h01);
    chk("motor", motor(), 16'h1ABC);
    go(6'h02);
    chk("motor", motor(), 16'h12BC);
    go(6'h03);
    chk("speed", {5'h00, speed}, 16'h0000);
    go(6'h05);
    chk("motor", motor(), 16'h1B20);
    wr_reg(8'h14, 16'h05DC);
    go(6'h05);
    chk("speed", {5'h00, speed}, 16'h058C);
    wr_reg(8'h00, 16'h0008);
    go(6'h05);
    chk("speed", {5'h00, speed}, 16'h05DC);
    wr_reg(8'h00, 16'h0003);
    remote <= 10'h280;
    go(6'h01);
    chk("speed", {5'h00, speed}, 16'h03E8);
    wr_reg(8'h00, 16'h0001);
    remote <= 10'h140;
    go(6'h01);
    chk("speed", {5'h00, speed}, 16'h03E8);
    go(6'h05);
    chk("speed", {5'h00, speed}, 16'h058C);
    wr_reg(8'h00, 16'h0000);
    go(6'h11);
    chk("motor", motor(), 16'h0800);
    test_cmd(16'h0001);
    chk("test", {15'h0000, test_act}, 16'h0000);
    go(6'h00);
    test_cmd(16'h0001);
    chk("test", {15'h0000, test_act}, 16'h0001);
    chk("motor", motor(), 16'h192C);
    test_cmd(16'h0002);
    chk("speed", {5'h00, speed}, 16'h0000);
    go(6'h03);
    test_cmd(16'h0001);
    chk("error", {14'h0000, test_act, test_err}, 16'h0001);
    test_cmd(16'h0004);
    go(6'h00);
    chk("error", {15'h0000, test_err}, 16'h0000);
    wr_reg(8'h00, 16'h0004);
    go(6'h01);
    chk("motor", motor(), 16'h12BC);
    wr_reg(8'h30, 16'h0001);
    go(6'h00);
    chk("ramp", {14'h0000, drive_en, speed != 11'h000}, 16'h0003);
    go(6'h03);
    chk("speed", {5'h00, speed}, 16'h0000);
    wr_reg(8'h00, 16'h0000);
    pol <= 1'b1;
    go(6'h03);
    go(6'h01);
    chk("motor", motor(), 16'h1ABC);
    // Clock enable low freezes the sequencer; both runs act only once it is back
    @(posedge ref_clk_i);
    ce <= 1'b0;
    go(6'h03);
    chk("frozen", {5'h00, speed}, 16'h02BC);
    @(posedge ref_clk_i);
    ce <= 1'b1;
    go(6'h03);
    chk("speed", {5'h00, speed}, 16'h0000);
    close_out();
  end
endmodule
bind motor_run_speed_sequencer motor_run_speed_sequencer_properties #(.FILT_CYCLES(FILT_CYCLES)) chk_u (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .forward_run_input_i(forward_run_input_i),
  .reverse_run_input_i(reverse_run_input_i), .coast_release_i(coast_release_i),
  .input_polarity_switch_i(input_polarity_switch_i), .rd_i(rd_i), .rdata_o(rdata_o), .drive_en_o(drive_en_o),
  .dir_cw_o(dir_cw_o), .speed_o(speed_o), .power_on_run_alarm_o(power_on_run_alarm_o),
  .alarm_code_o(alarm_code_o), .test_active_o(test_active_o));
`default_nettype wire
